// ---- hw/biie_exec.sv ----
// file: execution unit for interrupt enable, jumps, increment and software interrupt
`timescale 1ns/10ps
`default_nettype none

// Operation
// - irq disable clears global enable in one cycle, flags untouched
// - irq enable sets global enable in one cycle, flags untouched
// - direct jump: pc[8:0] from immediate, pc[10:9] from page buffer bits 2:1
// - direct jump takes two cycles, fetched instruction discarded, flags untouched
// - table jump: pc[10:8] from table pointer bits 2:0, pc[7:0] from accumulator
// - table jump takes two cycles, flags untouched
// - increment register, destination select picks accumulator or register, zero flag only
// - software interrupt pushes next address, loads pc with 0x001, three cycles
module biie_exec
    import biie_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // instruction from decoder
    input  wire logic              instr_valid_i,
    input  wire biie_instr_t       instr_i,
    output logic                   instr_ready_o,
    // core state inputs
    input  wire logic [7:0]        accumulator_i,
    input  wire logic [7:0]        reg_rdata_i,
    input  wire logic [2:0]        page_high_buffer_i,
    input  wire logic [7:0]        table_high_pointer_i,
    // program counter and stack
    output logic      [PC_W-1:0]   pc_o,
    output logic                   flush_o,
    output logic                   push_o,
    output logic      [PC_W-1:0]   push_addr_o,
    // write-back and global enable
    output biie_wb_t               wb_o,
    output logic                   global_irq_enable_o
);

    // ************************************************************
    // reset synchroniser
    // ************************************************************
    logic rst_s1_q;
    logic rst_s2_q;

    // release reset through two flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire logic rst_n;
    assign rst_n = rst_s2_q;

    // ************************************************************
    // sequencing
    // ************************************************************
    biie_state_t state_q;
    logic [1:0]  cnt_q;
    logic        take;
    logic        pc_load;
    logic [PC_W-1:0] pc_next;

    assign instr_ready_o = (state_q == ST_IDLE);
    assign take          = instr_valid_i && instr_ready_o;

    // multi-cycle ops hold the unit busy for their remaining cycles
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take && (instr_i.op == OP_DJUMP || instr_i.op == OP_TJUMP)) begin
                        state_q <= ST_BUSY;
                        cnt_q   <= JUMP_CYC - 2'h1;
                    end else if (take && instr_i.op == OP_SWI) begin
                        state_q <= ST_BUSY;
                        cnt_q   <= SWI_CYC - 2'h1;
                    end
                end
                ST_BUSY: begin
                    cnt_q <= cnt_q - 2'h1;
                    if (cnt_q == 2'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // jump target assembly
    // ************************************************************
    always_comb begin
        pc_load = 1'b0;
        pc_next = pc_o;
        if (take) begin
            case (instr_i.op)
                OP_DJUMP: begin
                    pc_load = 1'b1;
                    pc_next = {page_high_buffer_i[2:PHB_LO], instr_i.imm};
                end
                OP_TJUMP: begin
                    pc_load = 1'b1;
                    pc_next = {table_high_pointer_i[TBP_W-1:0], accumulator_i};
                end
                OP_SWI: begin
                    pc_load = 1'b1;
                    pc_next = SWI_VECTOR;
                end
                default: begin
                    pc_load = 1'b0;
                end
            endcase
        end
    end

    biie_pc_reg #(
        .W (PC_W)
    ) u_pc (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .load_i  (pc_load),
        .value_i (pc_next),
        .pc_o    (pc_o)
    );

    // ************************************************************
    // flush and stack push
    // ************************************************************
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            flush_o     <= 1'b0;
            push_o      <= 1'b0;
            push_addr_o <= '0;
        end else begin
            flush_o <= pc_load;
            push_o  <= take && instr_i.op == OP_SWI;
            if (take && instr_i.op == OP_SWI) begin
                push_addr_o <= pc_o + 11'h001;
            end
        end
    end

    // ************************************************************
    // global interrupt enable
    // ************************************************************
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            global_irq_enable_o <= IRQ_EN_RST;
        end else if (take && instr_i.op == OP_IRQ_DIS) begin
            global_irq_enable_o <= 1'b0;
        end else if (take && instr_i.op == OP_IRQ_EN) begin
            global_irq_enable_o <= 1'b1;
        end
    end

    // ************************************************************
    // increment and write-back
    // ************************************************************
    logic [7:0] inc_res;
    assign inc_res = reg_rdata_i + 8'h01;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_o <= '0;
        end else begin
            wb_o.accum_we <= take && instr_i.op == OP_INC && !instr_i.dest;
            wb_o.reg_we   <= take && instr_i.op == OP_INC && instr_i.dest;
            wb_o.z_we     <= take && instr_i.op == OP_INC;
            wb_o.raddr  <= instr_i.raddr;
            wb_o.data   <= inc_res;
            wb_o.z      <= (inc_res == 8'h00);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    disable_clears_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_IRQ_DIS |=> !global_irq_enable_o)
        else $error("global enable not cleared");

    enable_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_IRQ_EN |=> global_irq_enable_o && !wb_o.z_we)
        else $error("global enable not set");

    djump_target_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_DJUMP
        |=> pc_o == {$past(page_high_buffer_i[2:1]), $past(instr_i.imm)})
        else $error("direct jump target wrong");

    djump_two_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_DJUMP |=> flush_o && !instr_ready_o ##1 instr_ready_o)
        else $error("direct jump length wrong");

    tjump_target_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_TJUMP
        |=> pc_o == {$past(table_high_pointer_i[2:0]), $past(accumulator_i)})
        else $error("table jump target wrong");

    tjump_two_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_TJUMP |=> !instr_ready_o && !wb_o.z_we ##1 instr_ready_o)
        else $error("table jump length wrong");

    inc_dest_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_INC
        |=> wb_o.z_we && (wb_o.reg_we == $past(instr_i.dest)) && (wb_o.accum_we != wb_o.reg_we))
        else $error("increment destination wrong");

    swi_seq_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_SWI
        |=> push_o && pc_o == 11'h001 && push_addr_o == $past(pc_o) + 11'h001
            ##0 !instr_ready_o [*2] ##1 instr_ready_o)
        else $error("software interrupt sequence wrong");

    inc_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        take && instr_i.op == OP_INC && reg_rdata_i == 8'hFF
        |=> wb_o.data == 8'h00 && wb_o.z)
        else $error("increment wrap wrong");

endmodule : biie_exec
`default_nettype wire

// ---- hw/biie_pkg.sv ----
// package: opcodes, widths, constants and carrier structs for the exec block
package biie_pkg;

    // ************************************************************
    // widths and constants
    // ************************************************************
    localparam int unsigned PC_W        = 11;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned RADDR_W     = 7;
    localparam logic [10:0] SWI_VECTOR  = 11'h001;
    localparam logic        IRQ_EN_RST  = 1'b0;
    localparam logic [1:0]  JUMP_CYC    = 2'h2;
    localparam logic [1:0]  SWI_CYC     = 2'h3;
    localparam int unsigned PHB_LO      = 1;   // page_high_buffer bit copied to pc[9]
    localparam int unsigned JMP_IMM_W   = 9;
    localparam int unsigned TBP_W       = 3;

    // ************************************************************
    // operation codes presented by the decoder
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_IRQ_DIS = 3'b001,
        OP_IRQ_EN  = 3'b010,
        OP_DJUMP   = 3'b011,
        OP_TJUMP   = 3'b100,
        OP_INC     = 3'b101,
        OP_SWI     = 3'b110
    } biie_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BUSY  = 2'b01
    } biie_state_t;

    // instruction as handed in by the decoder
    typedef struct packed {
        biie_op_t            op;
        logic [8:0]          imm;      // direct jump target low bits
        logic [6:0]          raddr;    // data register address
        logic                dest;     // 0: accumulator, 1: register
    } biie_instr_t;

    // write-back to the data register file / accumulator
    typedef struct packed {
        logic                accum_we;
        logic                reg_we;
        logic [6:0]          raddr;
        logic [7:0]          data;
        logic                z_we;
        logic                z;
    } biie_wb_t;

endpackage : biie_pkg

// ---- hw/biie_pc_reg.sv ----
// file: program counter register with load port
`timescale 1ns/10ps
`default_nettype none

module biie_pc_reg
    import biie_pkg::*;
#(
    parameter int unsigned W = PC_W
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // load port
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    // current value
    output logic      [W-1:0] pc_o
);

    // holds value until loaded
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_o <= '0;
        end else if (load_i) begin
            pc_o <= value_i;
        end
    end

endmodule : biie_pc_reg
`default_nettype wire

// ---- bench/test_biie_exec.sv ----
// testbench: corner and random checks of the exec block
`timescale 1ns/10ps
`default_nettype none

module test_biie_exec
    import biie_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic            clock_i;
    logic            rst_n_i;
    logic            instr_valid_i;
    biie_instr_t     instr_i;
    logic            instr_ready_o;
    logic [7:0]      accumulator_i;
    logic [7:0]      reg_rdata_i;
    logic [2:0]      page_high_buffer_i;
    logic [7:0]      table_high_pointer_i;
    logic [PC_W-1:0] pc_o;
    logic            flush_o;
    logic            push_o;
    logic [PC_W-1:0] push_addr_o;
    biie_wb_t        wb_o;
    logic            global_irq_enable_o;
    logic [31:0]     ra;
    logic [31:0]     rb;
    logic [PC_W-1:0] pc_e;
    logic            irq_en_e;
    int              n_mismatch;
    int              check_count;

    // device under test
    biie_exec biie_exec_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr_ready_o(instr_ready_o), .accumulator_i(accumulator_i),
        .reg_rdata_i(reg_rdata_i), .page_high_buffer_i(page_high_buffer_i),
        .table_high_pointer_i(table_high_pointer_i), .pc_o(pc_o), .flush_o(flush_o),
        .push_o(push_o), .push_addr_o(push_addr_o), .wb_o(wb_o),
        .global_irq_enable_o(global_irq_enable_o)
    );

    // 100 MHz clock
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // compare one value, count it, report a difference
    task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // print the verdict and stop
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // reset held five cycles, then two synchroniser edges
    task automatic do_reset();
        rst_n_i = 1'h0;
        instr_valid_i = 1'h0;
        repeat (5) @(negedge clock_i);
        rst_n_i = 1'h1;
        repeat (2) @(negedge clock_i);
        pc_e = 11'h000;
        irq_en_e = IRQ_EN_RST;
        check("pc", pc_o, pc_e);
        check("irq_en", global_irq_enable_o, irq_en_e);
    endtask : do_reset

    // one instruction, entered at a falling edge, results checked a cycle later
    task automatic issue(input biie_op_t op, input logic [8:0] imm, input logic d,
        input logic [7:0] accum, input logic [7:0] r, input logic [2:0] pb, input logic [7:0] tb);
        logic [PC_W-1:0] tgt;
        logic [7:0]      sum;
        logic            jmp;
        jmp = (op == OP_DJUMP) || (op == OP_TJUMP) || (op == OP_SWI);
        tgt = (op == OP_DJUMP) ? {pb[2:1], imm} : (op == OP_TJUMP) ? {tb[2:0], accum} :
              (op == OP_SWI) ? 11'h001 : pc_e;
        sum = r + 8'h01;
        instr_valid_i = 1'h1;
        instr_i = '{op: op, imm: imm, raddr: imm[6:0], dest: d};
        accumulator_i = accum;
        reg_rdata_i = r;
        page_high_buffer_i = pb;
        table_high_pointer_i = tb;
        check("ready", instr_ready_o, 1'h1);
        @(negedge clock_i);
        if (op == OP_IRQ_DIS) irq_en_e = 1'h0;
        if (op == OP_IRQ_EN) irq_en_e = 1'h1;
        check("pc", pc_o, tgt);
        check("flush", flush_o, jmp);
        check("push", push_o, op == OP_SWI);
        if (op == OP_SWI) check("push_addr", push_addr_o, pc_e + 11'h001);
        check("irq_en", global_irq_enable_o, irq_en_e);
        check("accum_we", wb_o.accum_we, op == OP_INC && !d);
        check("reg_we", wb_o.reg_we, op == OP_INC && d);
        check("z_we", wb_o.z_we, op == OP_INC);
        if (op == OP_INC) check("raddr", wb_o.raddr, imm[6:0]);
        if (op == OP_INC) check("data", wb_o.data, sum);
        if (op == OP_INC) check("z", wb_o.z, sum == 8'h00);
        pc_e = tgt;
        if (jmp) begin
            instr_valid_i = 1'h0;
            check("busy", instr_ready_o, 1'h0);
            if (op == OP_SWI) @(negedge clock_i);
            if (op == OP_SWI) check("busy", instr_ready_o, 1'h0);
            @(negedge clock_i);
            check("ready", instr_ready_o, 1'h1);
            check("hold", pc_o, pc_e);
        end
    endtask : issue

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        instr_i = '0;
        accumulator_i = 8'h00;
        reg_rdata_i = 8'h00;
        page_high_buffer_i = 3'h0;
        table_high_pointer_i = 8'h00;
        ra = 32'hC611;
        rb = 32'h0;
        n_mismatch = 0;
        check_count = 0;
        do_reset();
        // corner cases: enable toggles, top page, wrap of return address
        issue(OP_IRQ_EN, 9'h000, 1'h0, 8'h00, 8'h00, 3'h0, 8'h00);
        issue(OP_IRQ_DIS, 9'h000, 1'h0, 8'h00, 8'h00, 3'h0, 8'h00);
        issue(OP_IRQ_EN, 9'h000, 1'h0, 8'h00, 8'h00, 3'h0, 8'h00);
        issue(OP_DJUMP, 9'h1FF, 1'h0, 8'h00, 8'h00, 3'h7, 8'h00);
        issue(OP_SWI, 9'h000, 1'h0, 8'h00, 8'h00, 3'h0, 8'h00);
        issue(OP_TJUMP, 9'h000, 1'h0, 8'h34, 8'h00, 3'h0, 8'hFA);
        issue(OP_DJUMP, 9'h055, 1'h0, 8'h00, 8'h00, 3'h3, 8'h00);
        issue(OP_INC, 9'h07F, 1'h0, 8'h00, 8'hFF, 3'h0, 8'h00);
        issue(OP_INC, 9'h011, 1'h1, 8'h00, 8'hFF, 3'h0, 8'h00);
        issue(OP_NONE, 9'h000, 1'h1, 8'h00, 8'h00, 3'h0, 8'h00);
        // random traffic
        for (int k = 0; k < 120; k++) begin
            ra = xorshift(ra);
            rb = xorshift(ra);
            ra = rb;
            issue((rb[2:0] == 3'h7) ? OP_NONE : biie_op_t'(rb[2:0]), rb[11:3], rb[12],
                  rb[20:13], rb[28:21], rb[31:29], {rb[4:0], rb[31:29]});
        end
        // reset in mid-run, then work resumes
        do_reset();
        issue(OP_INC, 9'h000, 1'h0, 8'h00, 8'h7F, 3'h0, 8'h00);
        instr_valid_i = 1'h0;
        @(negedge clock_i);
        give_verdict();
    end

endmodule : test_biie_exec

`default_nettype wire
